// File: rtl/ptp_cls_pkg.sv
package ptp_cls_pkg;

	// ==========================================================
	// Register map (printed offsets are indices; byte address = 4 * index)
	localparam logic [11:0] CFG_A_IDX    = 12'h514;
	localparam logic [11:0] CFG_B_IDX    = 12'h516;
	localparam logic [11:0] STATUS_IDX   = 12'h520;
	localparam int          ADDR_W       = 16;
	localparam logic [ADDR_W-1:0] CFG_A_ADDR  = ADDR_W'({CFG_A_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] CFG_B_ADDR  = ADDR_W'({CFG_B_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'({STATUS_IDX, 2'b00});

	// ==========================================================
	// Config A fields
	localparam int          A_AS_BIT     = 7;
	localparam int          A_EN_BIT     = 6;
	localparam int          A_RAW_BIT    = 5;
	localparam int          A_V4_BIT     = 4;
	localparam int          A_V6_BIT     = 3;
	localparam int          A_P2P_BIT    = 2;
	localparam int          A_MST_BIT    = 1;
	localparam int          A_ONE_BIT    = 0;
	localparam logic [15:0] CFG_A_RESET  = 16'h0039;
	localparam logic [15:0] CFG_A_MASK   = 16'h00ff;

	// ==========================================================
	// Config B fields
	localparam int          B_UNI_BIT    = 12;
	localparam int          B_ALT_BIT    = 11;
	localparam int          B_PRIO_BIT   = 10;
	localparam int          B_FU_BIT     = 9;
	localparam logic [15:0] CFG_B_RESET  = 16'h1004;
	localparam logic [15:0] CFG_B_MASK   = 16'h1fff;

	// ==========================================================
	// Protocol constants
	localparam logic [15:0] UDP_EVENT_PORT   = 16'h013f;
	localparam logic [15:0] UDP_GENERAL_PORT = 16'h0140;
	localparam logic [3:0]  MSG_SYNC         = 4'h0;
	localparam logic [3:0]  MSG_DELAY_REQ    = 4'h1;
	localparam logic [3:0]  MSG_FOLLOW_UP    = 4'h8;
	localparam int          MSG_GENERAL_BIT  = 3;
	localparam int          SRC_ID_W         = 80;

	typedef enum logic [1:0] {ENC_OTHER, ENC_RAW, ENC_IPV4, ENC_IPV6} encap_t;

	typedef struct packed {
		encap_t                encap;
		logic [3:0]            msg_type;
		logic [15:0]           udp_port;
		logic                  reserved_addr;
		logic                  from_host;
		logic                  from_master;
		logic                  same_domain;
		logic [7:0]            domain;
		logic [15:0]           seq_id;
		logic [SRC_ID_W-1:0]   src_id;
	} frame_desc_t;

	typedef struct packed {
		logic recognised;
		logic to_host;
		logic to_nonhost;
		logic use_lookup;
		logic high_prio;
		logic hdr_mod;
		logic insert_ts;
		logic tail_ts;
		logic p2p;
		logic master;
		logic one_step;
	} frame_dec_t;

endpackage : ptp_cls_pkg

// File: rtl/ptp_message_classifier_config.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module ptp_message_classifier_config
	import ptp_cls_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_in_valid,
	output logic                   o_in_ready,
	input  wire frame_desc_t       i_in_desc,
	output logic                   o_out_valid,
	input  wire logic              i_out_ready,
	output frame_dec_t             o_out_dec,
	output logic                   o_ptp_clk_en,
	output logic                   o_tail_ts_en
);

	// ==========================================================
	// APB slave
	logic [15:0] cfg_a_q;
	logic [15:0] cfg_a_d;
	logic [15:0] cfg_b_q;
	logic [15:0] cfg_b_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [15:0] status_w;
	logic [15:0] wmask_w;

	wire sel_a      = (i_paddr == CFG_A_ADDR);
	wire sel_b      = (i_paddr == CFG_B_ADDR);
	wire sel_st     = (i_paddr == STATUS_ADDR);
	wire mapped     = sel_a | sel_b | sel_st;
	wire setup_ph   = i_psel & ~i_penable;
	wire access_ph  = i_psel & i_penable;
	wire wr_fire    = access_ph & i_pwrite & mapped;
	wire wr_a       = wr_fire & sel_a;
	wire wr_b       = wr_fire & sel_b;

	assign o_pready  = 1'b1;
	assign o_pslverr = access_ph & ~mapped;
	assign o_prdata  = prdata_q;
	assign wmask_w   = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

	// Write takes effect at the access edge only, so classification sees it next cycle
	assign cfg_a_d = wr_a ? (((cfg_a_q & ~wmask_w) | (i_pwdata[15:0] & wmask_w)) & CFG_A_MASK)
	                      : cfg_a_q;
	assign cfg_b_d = wr_b ? (((cfg_b_q & ~wmask_w) | (i_pwdata[15:0] & wmask_w)) & CFG_B_MASK)
	                      : cfg_b_q;

	// Read data captured in the setup phase, stable through access
	assign prdata_d = ~(setup_ph & ~i_pwrite) ? prdata_q :
	                  sel_a  ? {16'h0000, cfg_a_q} :
	                  sel_b  ? {16'h0000, cfg_b_q} :
	                  sel_st ? {16'h0000, status_w} : 32'h0000_0000;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_a_q  <= CFG_A_RESET;
			cfg_b_q  <= CFG_B_RESET;
			prdata_q <= 32'h0000_0000;
		end else begin
			cfg_a_q  <= cfg_a_d;
			cfg_b_q  <= cfg_b_d;
			prdata_q <= prdata_d;
		end
	end

	// ==========================================================
	// Mode decode
	wire ptp_en    = cfg_a_q[A_EN_BIT];
	wire as_active = cfg_a_q[A_AS_BIT] & ptp_en;
	wire uni_en    = cfg_b_q[B_UNI_BIT];
	wire alt_en    = cfg_b_q[B_ALT_BIT];
	wire prio_all  = cfg_b_q[B_PRIO_BIT];
	wire fu_chk    = cfg_b_q[B_FU_BIT];

	assign o_ptp_clk_en = ptp_en;
	assign o_tail_ts_en = ptp_en;

	// ==========================================================
	// Classification
	logic                 sync_vld_q;
	logic [7:0]           sync_dom_q;
	logic [15:0]          sync_seq_q;
	logic [SRC_ID_W-1:0]  sync_src_q;
	frame_dec_t           dec_w;

	wire is_ip      = (i_in_desc.encap == ENC_IPV4) | (i_in_desc.encap == ENC_IPV6);
	wire encap_ok   = ((i_in_desc.encap == ENC_RAW)  & cfg_a_q[A_RAW_BIT])
	                | ((i_in_desc.encap == ENC_IPV4) & cfg_a_q[A_V4_BIT])
	                | ((i_in_desc.encap == ENC_IPV6) & cfg_a_q[A_V6_BIT]);
	wire port_ok    = (i_in_desc.udp_port == UDP_EVENT_PORT) |
	                  (i_in_desc.udp_port == UDP_GENERAL_PORT);
	wire uni_hit    = uni_en & is_ip & port_ok & ~i_in_desc.reserved_addr;
	wire recog      = ptp_en & encap_ok & (i_in_desc.reserved_addr | uni_hit);
	wire is_unicast = recog & ~i_in_desc.reserved_addr;
	wire is_event   = ~i_in_desc.msg_type[MSG_GENERAL_BIT];
	wire is_sync    = (i_in_desc.msg_type == MSG_SYNC);
	wire is_sd      = is_sync | (i_in_desc.msg_type == MSG_DELAY_REQ);
	wire is_fu      = (i_in_desc.msg_type == MSG_FOLLOW_UP);
	wire master_sd  = is_sd & i_in_desc.from_master & ~i_in_desc.from_host;
	wire fu_match   = sync_vld_q & (sync_dom_q == i_in_desc.domain) &
	                  (sync_seq_q == i_in_desc.seq_id) & (sync_src_q == i_in_desc.src_id);
	wire fu_block   = fu_chk & is_fu & ~fu_match;
	wire push       = i_in_valid & o_in_ready;

	logic host_w;
	logic nonhost_w;
	always_comb begin
		host_w    = 1'b0;
		nonhost_w = 1'b0;
		if (!recog || is_unicast) begin
			host_w    = 1'b0;
			nonhost_w = 1'b0;
		end else if (as_active) begin
			host_w    = 1'b1;
		end else if (master_sd && i_in_desc.same_domain) begin
			host_w    = 1'b0;
			nonhost_w = alt_en;
		end else if (master_sd) begin
			nonhost_w = 1'b1;
		end else begin
			host_w    = ~fu_block;
		end
	end

	always_comb begin
		dec_w            = '0;
		dec_w.recognised = recog;
		dec_w.to_host    = host_w;
		dec_w.to_nonhost = nonhost_w;
		dec_w.use_lookup = ~recog | is_unicast;
		dec_w.high_prio  = recog & (prio_all | is_event);
		dec_w.hdr_mod    = recog & ~as_active;
		dec_w.insert_ts  = recog & ~as_active & is_event;
		dec_w.tail_ts    = recog;
		dec_w.p2p        = cfg_a_q[A_P2P_BIT];
		dec_w.master     = cfg_a_q[A_MST_BIT];
		dec_w.one_step   = cfg_a_q[A_ONE_BIT];
	end

	// Last Sync identifiers for Follow_up pairing
	wire sync_cap = push & recog & is_sync;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_vld_q <= 1'b0;
			sync_dom_q <= 8'h00;
			sync_seq_q <= 16'h0000;
			sync_src_q <= '0;
		end else if (sync_cap) begin
			sync_vld_q <= 1'b1;
			sync_dom_q <= i_in_desc.domain;
			sync_seq_q <= i_in_desc.seq_id;
			sync_src_q <= i_in_desc.src_id;
		end
	end

	// ==========================================================
	// Two-entry decision buffer
	localparam int DEPTH = 2;
	frame_dec_t  buf_q [DEPTH];
	logic        wp_q;
	logic        rp_q;
	logic [1:0]  cnt_q;
	logic [1:0]  cnt_d;

	wire full  = (cnt_q == 2'(DEPTH));
	wire empty = (cnt_q == 2'd0);
	wire pop   = o_out_valid & i_out_ready;

	assign o_in_ready  = ~full;
	assign o_out_valid = ~empty;
	assign o_out_dec   = buf_q[rp_q];
	assign cnt_d       = cnt_q + {1'b0, push} - {1'b0, pop};
	assign status_w    = {11'h000, cnt_q, sync_vld_q, as_active, ptp_en};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			wp_q  <= wp_q ^ push;
			rp_q  <= rp_q ^ pop;
			cnt_q <= cnt_d;
		end
	end

	for (genvar g = 0; g < DEPTH; g++) begin : g_buf
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				buf_q[g] <= '0;
			end else if (push && (wp_q == 1'(g))) begin
				buf_q[g] <= dec_w;
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_wr_a_full;
		wr_a && (i_pstrb[1:0] == 2'b11);
	endsequence

	property p_as_gate;
		!cfg_a_q[A_EN_BIT] |-> !as_active && !dec_w.recognised;
	endproperty
	a_as_gate: assert property (p_as_gate) else $error("802.1AS active without enable");

	property p_as_host;
		push && recog && as_active && !is_unicast |-> dec_w.to_host && !dec_w.hdr_mod;
	endproperty
	a_as_host: assert property (p_as_host) else $error("802.1AS frame not sent to host");

	property p_clk_follows_write;
		s_wr_a_full |=> (o_ptp_clk_en == $past(i_pwdata[A_EN_BIT]));
	endproperty
	a_clk_follows_write: assert property (p_clk_follows_write)
		else $error("Clock enable not following write");

	property p_raw_off;
		push && (i_in_desc.encap == ENC_RAW) && !cfg_a_q[A_RAW_BIT] |-> !dec_w.recognised;
	endproperty
	a_raw_off: assert property (p_raw_off) else $error("Raw frame recognised while off");

	property p_unicast;
		push && dec_w.recognised && !i_in_desc.reserved_addr
			|-> uni_en && dec_w.use_lookup && !dec_w.to_host;
	endproperty
	a_unicast: assert property (p_unicast) else $error("Unicast handling wrong");

	property p_alt_drop;
		push && recog && !as_active && master_sd && i_in_desc.same_domain && !is_unicast
			|-> !dec_w.to_host && (dec_w.to_nonhost == alt_en);
	endproperty
	a_alt_drop: assert property (p_alt_drop) else $error("Alternate master handling wrong");

	property p_prio;
		push && recog && !prio_all && !is_event |-> !dec_w.high_prio;
	endproperty
	a_prio: assert property (p_prio) else $error("General message given high priority");

	property p_fu_pair;
		push && recog && !as_active && fu_chk && is_fu && !fu_match |-> !dec_w.to_host;
	endproperty
	a_fu_pair: assert property (p_fu_pair) else $error("Unmatched Follow_up sent to host");

	sequence s_push_stall;
		push && !pop;
	endsequence

	property p_buf_hold;
		s_push_stall ##1 (!pop && !push) [*2] |-> (cnt_q == $past(cnt_q, 2) + 2'd1) && o_out_valid;
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("Buffer lost a decision");

	property p_cfg_write;
		s_wr_a_full |=> cfg_a_q == ($past(i_pwdata[15:0]) & CFG_A_MASK);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("Config write not applied");

	property p_v4_off;
		push && (i_in_desc.encap == ENC_IPV4) && !cfg_a_q[A_V4_BIT] |-> !dec_w.recognised;
	endproperty
	a_v4_off: assert property (p_v4_off) else $error("IPv4 frame recognised while off");

	property p_v6_off;
		push && (i_in_desc.encap == ENC_IPV6) && !cfg_a_q[A_V6_BIT] |-> !dec_w.recognised;
	endproperty
	a_v6_off: assert property (p_v6_off) else $error("IPv6 frame recognised while off");

	property p_other_encap;
		push && (i_in_desc.encap == ENC_OTHER) |-> !dec_w.recognised;
	endproperty
	a_other_encap: assert property (p_other_encap) else $error("Unknown encapsulation recognised");

	property p_mode_bits;
		push |-> (dec_w.p2p == cfg_a_q[A_P2P_BIT]) && (dec_w.master == cfg_a_q[A_MST_BIT])
			&& (dec_w.one_step == cfg_a_q[A_ONE_BIT]);
	endproperty
	a_mode_bits: assert property (p_mode_bits) else $error("Clock mode bits wrong");

	property p_tail_ts;
		push && dec_w.recognised |-> dec_w.tail_ts && o_tail_ts_en;
	endproperty
	a_tail_ts: assert property (p_tail_ts) else $error("Tail timestamp missing");

	property p_ts_event;
		push && dec_w.insert_ts |-> is_event && ptp_en && !as_active;
	endproperty
	a_ts_event: assert property (p_ts_event) else $error("Timestamp on wrong message");

	property p_multicast_only;
		push && !uni_en && !i_in_desc.reserved_addr |-> !dec_w.recognised;
	endproperty
	a_multicast_only: assert property (p_multicast_only) else $error("Unicast while off");

	property p_port_check;
		push && !port_ok && !i_in_desc.reserved_addr |-> !dec_w.recognised;
	endproperty
	a_port_check: assert property (p_port_check) else $error("Unicast on wrong port");

	property p_prio_all;
		push && recog && prio_all |-> dec_w.high_prio;
	endproperty
	a_prio_all: assert property (p_prio_all) else $error("Message not high priority");

	property p_event_prio;
		push && recog && is_event |-> dec_w.high_prio;
	endproperty
	a_event_prio: assert property (p_event_prio) else $error("Event not high priority");

	property p_fu_match;
		push && recog && !as_active && !is_unicast && is_fu && fu_match |-> dec_w.to_host;
	endproperty
	a_fu_match: assert property (p_fu_match) else $error("Matched Follow_up not sent to host");

	property p_no_dual;
		push |-> !(dec_w.to_host && dec_w.to_nonhost);
	endproperty
	a_no_dual: assert property (p_no_dual) else $error("Host and non-host both chosen");

	property p_clk_stops;
		!cfg_a_q[A_EN_BIT] |-> !o_ptp_clk_en && !o_tail_ts_en;
	endproperty
	a_clk_stops: assert property (p_clk_stops) else $error("Clock enabled without enable");

	property p_full_block;
		(cnt_q == 2'(DEPTH)) |-> !o_in_ready;
	endproperty
	a_full_block: assert property (p_full_block) else $error("Ready while buffer full");

	property p_out_hold;
		o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_dec);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("Decision changed while stalled");

	property p_sync_latch;
		sync_cap |=> sync_vld_q && (sync_seq_q == $past(i_in_desc.seq_id));
	endproperty
	a_sync_latch: assert property (p_sync_latch) else $error("Sync identifiers not stored");

	property p_cfg_b_write;
		wr_b && (i_pstrb[1:0] == 2'b11) |=> cfg_b_q == ($past(i_pwdata[15:0]) & CFG_B_MASK);
	endproperty
	a_cfg_b_write: assert property (p_cfg_b_write) else $error("Config B write not applied");

endmodule : ptp_message_classifier_config

// File: verif/host_sink.sv
`timescale 1ns/1ps
// ==========
// Host-side decision sink, stalls on request and at random
module host_sink (
	input  wire logic i_clk,
	input  wire logic i_stall,
	output logic      o_ready = 1'b0
);
	always @(posedge i_clk) begin
		o_ready <= !i_stall && ($urandom % 4 != 0);
	end
endmodule : host_sink

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench
	import ptp_cls_pkg::*;
;
	logic              clk      = 1'b0;
	logic              rst_n    = 1'b0;
	logic              psel     = 1'b0;
	logic              penable  = 1'b0;
	logic              pwrite   = 1'b0;
	logic [ADDR_W-1:0] paddr    = '0;
	logic [31:0]       pwdata   = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              in_valid = 1'b0;
	logic              in_ready;
	frame_desc_t       in_desc  = '0;
	logic              out_valid;
	logic              out_ready;
	frame_dec_t        out_dec;
	logic              clk_en;
	logic              tail_en;
	logic              stall    = 1'b0;
	logic [15:0]       cfg_a    = 16'h0039;
	logic [15:0]       cfg_b    = 16'h1004;
	int                errors   = 0;
	int                n_checks = 0;
	int                cycles   = 0;
	frame_dec_t        exp_q[$];
	frame_dec_t        e_mon;
	frame_desc_t       d;
	logic              sh_vld   = 1'b0;
	logic [7:0]        sh_dom   = '0;
	logic [15:0]       sh_seq   = '0;
	logic [SRC_ID_W-1:0] sh_src = '0;

	ptp_message_classifier_config u_ptp_message_classifier_config (
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_in_valid(in_valid), .o_in_ready(in_ready),
		.i_in_desc(in_desc), .o_out_valid(out_valid), .i_out_ready(out_ready),
		.o_out_dec(out_dec), .o_ptp_clk_en(clk_en), .o_tail_ts_en(tail_en));
	host_sink u_host_sink (.i_clk(clk), .i_stall(stall), .o_ready(out_ready));

	initial begin
		forever #4 clk = ~clk;
	end

	// ==========
	// Shared tasks
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, '0, rd, err);
		check("prdata", exp, rd);
		check("pslverr", {31'h0, e}, {31'h0, err});
	endtask : rd_chk

	task automatic cfg(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, CFG_A_ADDR, {16'h0, a}, rd, err);
		apb(1'b1, CFG_B_ADDR, {16'h0, b}, rd, err);
		cfg_a = a & CFG_A_MASK;
		cfg_b = b & CFG_B_MASK;
	endtask : cfg

	function automatic frame_desc_t mk(encap_t enc, logic [3:0] t, logic rsv, logic mst,
			logic dom, logic [15:0] seq);
		frame_desc_t f = '0;
		f.encap = enc;
		f.msg_type = t;
		f.reserved_addr = rsv;
		f.from_master = mst;
		f.same_domain = dom;
		f.seq_id = seq;
		f.udp_port = UDP_EVENT_PORT;
		return f;
	endfunction : mk

	// Expected decision from the shadow config; xm picks fields a scenario pins to xe
	task automatic send(input frame_desc_t f, input frame_dec_t xm, input frame_dec_t xe);
		frame_dec_t e;
		logic       en;
		logic       uni;
		logic       as_on;
		logic       sd;
		logic       hit;
		en = (f.encap == ENC_RAW && cfg_a[A_RAW_BIT]) || (f.encap == ENC_IPV4 && cfg_a[A_V4_BIT])
			|| (f.encap == ENC_IPV6 && cfg_a[A_V6_BIT]);
		uni = cfg_b[B_UNI_BIT] && f.encap inside {ENC_IPV4, ENC_IPV6} && !f.reserved_addr
			&& f.udp_port inside {UDP_EVENT_PORT, UDP_GENERAL_PORT};
		as_on = cfg_a[A_AS_BIT] && cfg_a[A_EN_BIT];
		sd = f.msg_type inside {MSG_SYNC, MSG_DELAY_REQ} && f.from_master && !f.from_host;
		hit = sh_vld && f.domain == sh_dom && f.seq_id == sh_seq && f.src_id == sh_src;
		e = '0;
		e.recognised = cfg_a[A_EN_BIT] && en && (f.reserved_addr || uni);
		e.use_lookup = !e.recognised || !f.reserved_addr;
		e.high_prio = e.recognised && (cfg_b[B_PRIO_BIT] || !f.msg_type[MSG_GENERAL_BIT]);
		e.hdr_mod = e.recognised && !as_on;
		e.insert_ts = e.hdr_mod && !f.msg_type[MSG_GENERAL_BIT];
		e.tail_ts = e.recognised;
		e.p2p = cfg_a[A_P2P_BIT];
		e.master = cfg_a[A_MST_BIT];
		e.one_step = cfg_a[A_ONE_BIT];
		if (e.recognised && f.reserved_addr) begin
			if (as_on) e.to_host = 1'b1;
			else if (sd) e.to_nonhost = !f.same_domain || cfg_b[B_ALT_BIT];
			else e.to_host = !(cfg_b[B_FU_BIT] && f.msg_type == MSG_FOLLOW_UP) || hit;
		end
		if (e.recognised && f.msg_type == MSG_SYNC) begin
			sh_vld = 1'b1;
			sh_dom = f.domain;
			sh_seq = f.seq_id;
			sh_src = f.src_id;
		end
		exp_q.push_back(frame_dec_t'((e & ~xm) | (xe & xm)));
		@(posedge clk);
		in_valid <= 1'b1;
		in_desc <= f;
		@(posedge clk);
		while (in_ready !== 1'b1) @(posedge clk);
		in_valid <= 1'b0;
	endtask : send

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict

	always @(negedge clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("spare decision", 32'h0, 32'h1);
			end else begin
				e_mon = exp_q.pop_front();
				check("decision", 32'(e_mon), 32'(out_dec));
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end

	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'hcf7a));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(CFG_A_ADDR, 32'h0000_0039, 1'b0);
		rd_chk(CFG_B_ADDR, 32'h0000_1004, 1'b0);
		rd_chk(16'h0000, 32'h0000_0000, 1'b1);
		cfg(16'hffff, 16'hffff);
		rd_chk(CFG_A_ADDR, 32'h0000_00ff, 1'b0);
		rd_chk(CFG_B_ADDR, 32'h0000_1fff, 1'b0);
		cfg(16'h00b9, 16'h1004);
		check("clk_en", 32'h0, {31'h0, clk_en});
		rd_chk(STATUS_ADDR, 32'h0000_0000, 1'b0);
		$display("test registers done");
		cfg(16'h00f9, 16'h1004);
		check("clk_en", 32'h1, {31'h0, clk_en});
		check("tail_en", 32'h1, {31'h0, tail_en});
		send(mk(ENC_RAW, MSG_DELAY_REQ, 1'b1, 1'b0, 1'b1, 16'd1), 11'h620, 11'h600);
		cfg(16'h0079, 16'h1004);
		send(mk(ENC_RAW, MSG_DELAY_REQ, 1'b1, 1'b0, 1'b1, 16'd2), 11'h010, 11'h010);
		send(mk(ENC_RAW, MSG_SYNC, 1'b1, 1'b1, 1'b1, 16'd3), 11'h300, 11'h000);
		send(mk(ENC_RAW, MSG_SYNC, 1'b1, 1'b1, 1'b0, 16'd4), 11'h300, 11'h100);
		cfg(16'h0079, 16'h1804);
		send(mk(ENC_RAW, MSG_SYNC, 1'b1, 1'b1, 1'b1, 16'd5), 11'h300, 11'h100);
		cfg(16'h0079, 16'h1204);
		send(mk(ENC_RAW, MSG_SYNC, 1'b1, 1'b0, 1'b1, 16'd7), 11'h000, 11'h000);
		send(mk(ENC_RAW, MSG_FOLLOW_UP, 1'b1, 1'b0, 1'b1, 16'd7), 11'h200, 11'h200);
		send(mk(ENC_RAW, MSG_FOLLOW_UP, 1'b1, 1'b0, 1'b1, 16'd8), 11'h200, 11'h000);
		$display("test forwarding done");
		while (exp_q.size() != 0) @(posedge clk);
		stall <= 1'b1;
		cfg(16'h0079, 16'h1004);
		send(mk(ENC_RAW, MSG_FOLLOW_UP, 1'b1, 1'b0, 1'b0, 16'd9), 11'h0, 11'h0);
		send(mk(ENC_RAW, MSG_FOLLOW_UP, 1'b1, 1'b0, 1'b0, 16'd10), 11'h0, 11'h0);
		@(negedge clk);
		check("in_ready", 32'h0, {31'h0, in_ready});
		cfg(16'h0079, 16'h1404);
		stall <= 1'b0;
		send(mk(ENC_RAW, MSG_FOLLOW_UP, 1'b1, 1'b0, 1'b0, 16'd11), 11'h0, 11'h0);
		$display("test buffer done");
		repeat (4) begin
			cfg(16'h0040 | (16'($urandom) & 16'h003f), 16'($urandom) & 16'h1400);
			repeat (12) begin
				d = mk(encap_t'(2'($urandom)), 4'($urandom), 1'($urandom), 1'b0, 1'b1,
					16'($urandom));
				d.udp_port = ($urandom % 3 == 0) ? 16'($urandom) : UDP_GENERAL_PORT;
				send(d, 11'h0, 11'h0);
			end
		end
		$display("test random done");
		for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk);
		check("pending", 32'h0, 32'(exp_q.size()));
		print_verdict();
	end
endmodule : testbench
